// *** rtl/dispenser_cfg.svh ***
// constants for the trigger and ready logic block
`ifndef DISPENSER_CFG_SVH
`define DISPENSER_CFG_SVH
`define MAX_CH          16
`define ADDR_W          8
`define CLK_HZ          100000000
`define SEC_PER_MIN     60
`define STEPS_PER_REV   200
`define VOL_W           16
`define RATE_W          16
`define LEFT_W          24
`define ACC_W           35
`define IRQ_W           3
// register byte addresses
`define OFS_ENABLE      8'h00
`define OFS_MODE        8'h04
`define OFS_VOLUME      8'h08
`define OFS_RATE        8'h0c
`define OFS_REF         8'h10
`define OFS_STATE       8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1c
// interrupt status bits
`define IRQ_TRIG        0
`define IRQ_DONE        1
`define IRQ_FAULT       2
// field positions in the state register
`define STATE_FAULT_LSB 16
// channel mode codes
`define MODE_PRIME      2'h0
`define MODE_DISPENSE   2'h1
`define MODE_METER      2'h2
`endif

// *** rtl/dispenser_pkg.sv ***
// types shared by the trigger and ready logic block
`include "dispenser_cfg.svh"
package dispenser_pkg;
  typedef logic [1:0] chan_mode_t;

  typedef struct packed {
    logic                                 sys_s1;
    logic                                 sys_s2;
    logic                                 sys_s3;
    logic [`MAX_CH-1:0]                   trig_s1;
    logic [`MAX_CH-1:0]                   trig_s2;
    logic [`MAX_CH-1:0]                   trig_s3;
    logic [`MAX_CH-1:0]                   sel_prev;
    logic [`MAX_CH-1:0]                   en;
    logic [`MAX_CH-1:0]                   ref_need;
    logic [`MAX_CH-1:0][1:0]              mode;
    logic [`VOL_W-1:0]                    volume;
    logic [`RATE_W-1:0]                   rate;
    logic [`MAX_CH-1:0]                   busy;
    logic [`MAX_CH-1:0]                   metering;
    logic [`MAX_CH-1:0][`LEFT_W-1:0]      steps_left;
    logic [`MAX_CH-1:0][`ACC_W-1:0]       acc;
    logic [`MAX_CH-1:0]                   step;
    logic [`MAX_CH-1:0]                   fault_prev;
    logic [`IRQ_W-1:0]                    irq_stat;
    logic [`IRQ_W-1:0]                    irq_mask;
    logic                                 irq;
    logic [`MAX_CH-1:0]                   ready;
    logic                                 sys_ready;
    logic                                 sys_ok;
    logic [31:0]                          rdata;
  } state_t;
endpackage : dispenser_pkg

// *** rtl/dispenser_trigger_ready_io.sv ***
// trigger, ready and fault logic of a multi-channel pump dispensing controller
// What this block does
// R1 - a system trigger starts a cycle on every eligible idle channel in meter mode, or in dispense mode with nonzero volume
// R2 - channels in prime mode ignore the system trigger completely
// R3 - dispense mode fires eligible channels once on the trigger rising edge
// R4 - meter mode runs eligible channels while the trigger is held, stops on release
// R5 - disabled, faulted or reference-needing channels are never started by system trigger
// R6 - system ready is true only while every channel is ready
// R7 - system fault output is true while no channel is faulted
// R8 - each output is high (switch conducting) while its signal is true
// R9 - a channel trigger starts only its channel, in dispense or meter mode
// R10 - channel trigger is ignored in prime, on fault, or while reference is needed
// R11 - each channel has its own ready output showing idle versus busy
// R12 - a single channel can be started by its logic input alone
// R13 - volume is whole revolutions, rate is revolutions per minute
// R14 - two hundred motor steps are issued per commanded revolution
// R15 - no setting survives reset; all parameters return to defaults
// R16 - the controller must program all settings before relying on triggers
// R17 - software cannot enable a channel while its hold switch is engaged
// R18 - reset brings every channel up enabled unless its hold switch is engaged
// R19 - trigger inputs are synchronised and edge detected before use
`timescale 1ns/1ns
`default_nettype none
`include "dispenser_cfg.svh"
module dispenser_trigger_ready_io
  import dispenser_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              system_trigger_input,
  input  wire logic [NCH-1:0]    chan_trigger_in,
  input  wire logic [NCH-1:0]    chan_fault_in,
  input  wire logic [NCH-1:0]    channel_hold_disable_switch,
  input  wire logic [NCH-1:0]    chan_select_btn,
  output logic      [NCH-1:0]    chan_step_out,
  output logic      [NCH-1:0]    chan_ready_out,
  output logic                   sys_ready_out,
  output logic                   sys_fault_ok_out,
  output logic                   irq_out
);

  // one step is due each time the accumulator passes clock rate times a minute
  localparam logic [`ACC_W-1:0] STEP_LIMIT =
    `ACC_W'(64'(`CLK_HZ) * 64'(`SEC_PER_MIN));
  localparam logic [`MAX_CH-1:0] CH_MASK = `MAX_CH'((64'h1 << NCH) - 64'h1);

  generate
    if (NCH < 1 || NCH > `MAX_CH) begin : g_bad_nch
      $error("NCH must lie between 1 and MAX_CH");
    end
  endgenerate

  state_t q;
  state_t d;

  logic                      sys_edge;
  logic [`MAX_CH-1:0]        chan_edge;
  logic [`MAX_CH-1:0]        hold;
  logic [`MAX_CH-1:0]        fault;
  logic [`MAX_CH-1:0]        sel;
  logic [`MAX_CH-1:0]        elig;
  logic [`IRQ_W-1:0]         irq_set;
  logic [`IRQ_W-1:0]         irq_clr;
  logic [`LEFT_W-1:0]        step_inc;
  logic [`ACC_W-1:0]         acc_sum;
  logic                      run_meter;
  logic                      fire;

  // a channel may be started only while enabled, healthy, referenced and not priming
  function automatic logic eligible(input logic en, input logic flt,
                                    input logic refn, input chan_mode_t m);
    eligible = en & ~flt & ~refn & (m != `MODE_PRIME);
  endfunction : eligible

  // write decode shared by every register
  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // unused upper channels are held at zero so they never look busy or faulted
  assign hold  = `MAX_CH'(channel_hold_disable_switch);
  assign fault = `MAX_CH'(chan_fault_in);
  assign sel   = `MAX_CH'(chan_select_btn);

  // next-state logic for the whole block
  always_comb begin
    d         = q;
    irq_set   = '0;
    irq_clr   = '0;
    acc_sum   = '0;
    run_meter = 1'b0;
    fire      = 1'b0;
    step_inc  = `LEFT_W'(q.rate) * `LEFT_W'(`STEPS_PER_REV); // R14

    // two-stage synchronisers, third stage only feeds the edge detectors
    d.sys_s1  = system_trigger_input; // R19
    d.sys_s2  = q.sys_s1;
    d.sys_s3  = q.sys_s2;
    d.trig_s1 = `MAX_CH'(chan_trigger_in); // R19
    d.trig_s2 = q.trig_s1;
    d.trig_s3 = q.trig_s2;
    sys_edge  = q.sys_s2 & ~q.sys_s3; // R19
    chan_edge = q.trig_s2 & ~q.trig_s3 & CH_MASK;

    // momentary select toggles the software enable
    d.sel_prev = sel;
    d.en       = q.en ^ (sel & ~q.sel_prev);

    // register writes
    if (reg_wr) begin
      if (hit(reg_addr, `OFS_ENABLE)) begin
        d.en = `MAX_CH'(reg_wdata) & ~hold; // R17
      end
      if (hit(reg_addr, `OFS_MODE)) begin
        d.mode = reg_wdata;
      end
      if (hit(reg_addr, `OFS_VOLUME)) begin
        d.volume = reg_wdata[`VOL_W-1:0]; // R13
      end
      if (hit(reg_addr, `OFS_RATE)) begin
        d.rate = reg_wdata[`RATE_W-1:0]; // R13
      end
      if (hit(reg_addr, `OFS_REF)) begin
        d.ref_need = q.ref_need & ~`MAX_CH'(reg_wdata);
      end
      if (hit(reg_addr, `OFS_IRQ_STAT)) begin
        irq_clr = reg_wdata[`IRQ_W-1:0];
      end
      if (hit(reg_addr, `OFS_IRQ_MASK)) begin
        d.irq_mask = reg_wdata[`IRQ_W-1:0];
      end
    end
    // an engaged hold switch keeps the channel disabled whatever else happens
    d.en = d.en & ~hold & CH_MASK; // R18

    // per-channel cycle control and step generation
    for (int c = 0; c < `MAX_CH; c++) begin
      elig[c]   = eligible(q.en[c], fault[c], q.ref_need[c], q.mode[c]); // R5 R10
      d.step[c] = 1'b0;
      // meter: run while either trigger is held, stop on release
      run_meter = elig[c] & (q.mode[c] == `MODE_METER)
                  & (q.sys_s2 | q.trig_s2[c]); // R4 R9
      // dispense: one start per rising edge, system or own channel
      fire = elig[c] & (q.mode[c] == `MODE_DISPENSE) & ~q.busy[c]
             & (sys_edge | chan_edge[c]) & (q.volume != '0); // R1 R3 R9 R12
      if (q.mode[c] == `MODE_METER) begin
        if (q.busy[c] && !run_meter) begin
          irq_set[`IRQ_DONE] = 1'b1;
        end
        d.busy[c]     = run_meter;
        d.metering[c] = run_meter;
      end else if (fire) begin
        d.busy[c]       = 1'b1;
        d.metering[c]   = 1'b0;
        d.steps_left[c] = `LEFT_W'(q.volume) * `LEFT_W'(`STEPS_PER_REV); // R13 R14
      end else if (q.busy[c] && (!elig[c] || q.mode[c] != `MODE_DISPENSE)) begin
        // fault, disable or mode change aborts a dispense in progress
        d.busy[c]     = 1'b0;
        d.metering[c] = 1'b0;
      end else if (q.busy[c] && q.steps_left[c] == '0) begin
        // the last step has gone out, so ready rises only after that pulse
        d.busy[c]          = 1'b0;
        irq_set[`IRQ_DONE] = 1'b1;
      end
      // phase accumulator turns rpm into evenly spaced steps
      if (q.busy[c]) begin
        acc_sum = q.acc[c] + `ACC_W'(step_inc);
        if (acc_sum >= STEP_LIMIT) begin
          d.acc[c]  = acc_sum - STEP_LIMIT;
          d.step[c] = d.busy[c];
          if (!q.metering[c] && d.busy[c]) begin
            d.steps_left[c] = q.steps_left[c] - `LEFT_W'(1); // R14
          end
        end else begin
          d.acc[c] = acc_sum;
        end
      end else begin
        d.acc[c] = '0;
      end
    end
    d.busy     = d.busy & CH_MASK;
    d.metering = d.metering & CH_MASK;
    d.step     = d.step & CH_MASK;

    // interrupt events; a set in the clearing cycle survives
    if (sys_edge) begin
      irq_set[`IRQ_TRIG] = 1'b1;
    end
    d.fault_prev = fault;
    if ((fault & ~q.fault_prev) != '0) begin
      irq_set[`IRQ_FAULT] = 1'b1;
    end
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq      = (d.irq_stat & d.irq_mask) != '0;

    // pin outputs: high means the isolator switch conducts
    d.ready     = ~d.busy & CH_MASK; // R11 R8
    d.sys_ready = (d.ready & CH_MASK) == CH_MASK; // R6 R8
    d.sys_ok    = (fault & CH_MASK) == '0; // R7 R8

    // read data stands in the cycle after the strobe only
    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_ENABLE:   d.rdata = 32'(q.en);
        `OFS_MODE:     d.rdata = q.mode;
        `OFS_VOLUME:   d.rdata = 32'(q.volume);
        `OFS_RATE:     d.rdata = 32'(q.rate);
        `OFS_REF:      d.rdata = 32'(q.ref_need);
        `OFS_STATE: begin
          d.rdata = 32'(q.busy);
          d.rdata[`STATE_FAULT_LSB +: `MAX_CH] = fault;
        end
        `OFS_IRQ_STAT: d.rdata = 32'(q.irq_stat);
        `OFS_IRQ_MASK: d.rdata = 32'(q.irq_mask);
        default:       d.rdata = '0;
      endcase
    end
  end

  // state register; reset restores every setting since nothing is retained
  always_ff @(posedge clk) begin
    if (srst) begin
      q            <= '0; // R15
      q.en         <= CH_MASK; // R18
      q.ref_need   <= CH_MASK;
      q.ready      <= CH_MASK;
      q.sys_ready  <= 1'b1;
      q.sys_ok     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata        = q.rdata;
  assign chan_step_out    = q.step[NCH-1:0];
  assign chan_ready_out   = q.ready[NCH-1:0];
  assign sys_ready_out    = q.sys_ready;
  assign sys_fault_ok_out = q.sys_ok;
  assign irq_out          = q.irq;

endmodule : dispenser_trigger_ready_io
`default_nettype wire

// *** tb/trig_ready_chk.sv ***
// concurrent checks on the trigger, ready and fault ports
`timescale 1ns/1ns
`default_nettype none
module trig_ready_chk #(
  parameter int NCH = 4
) (
  input wire logic           clk,
  input wire logic           srst,
  input wire logic           system_trigger_input,
  input wire logic [NCH-1:0] chan_trigger_in,
  input wire logic [NCH-1:0] chan_fault_in,
  input wire logic [NCH-1:0] channel_hold_disable_switch,
  input wire logic [NCH-1:0] chan_step_out,
  input wire logic [NCH-1:0] chan_ready_out,
  input wire logic           sys_ready_out,
  input wire logic           sys_fault_ok_out,
  input wire logic           irq_out
);
  // any trigger line high; a channel may only go busy a few cycles after one
  wire trig_any = system_trigger_input | (|chan_trigger_in);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sys_ready_a: assert property (sys_ready_out == &chan_ready_out)
    else $error("system ready differs from channel readies");
  fault_on_a: assert property ((|chan_fault_in)[*3] |-> !sys_fault_ok_out)
    else $error("fault output still true with a faulted channel");
  fault_off_a: assert property ((chan_fault_in == '0)[*3] |-> sys_fault_ok_out)
    else $error("fault output false with no faulted channel");
  start_cause_a: assert property (|(~chan_ready_out & $past(chan_ready_out)) |->
    $past(trig_any, 3) || $past(trig_any, 4) || $past(trig_any, 5))
    else $error("channel went busy with no trigger");
  reset_state_a: assert property ($fell(srst) |->
    &chan_ready_out && sys_ready_out && !irq_out && chan_step_out == '0)
    else $error("outputs not at reset values");
  step_pulse_a: assert property ((chan_step_out & $past(chan_step_out)) == '0)
    else $error("step pulse longer than one cycle");
  step_busy_a: assert property ((chan_step_out & chan_ready_out) == '0)
    else $error("step issued on an idle channel");
  hold_block_a: assert property ((~chan_ready_out & channel_hold_disable_switch
    & $past(channel_hold_disable_switch, 5)) == '0)
    else $error("held channel is busy");
  fault_block_a: assert property ((~chan_ready_out & chan_fault_in
    & $past(chan_fault_in, 5)) == '0)
    else $error("faulted channel is busy");
endmodule : trig_ready_chk
bind dispenser_trigger_ready_io trig_ready_chk #(.NCH(NCH)) trig_ready_chk_i (
  .clk(clk), .srst(srst), .system_trigger_input(system_trigger_input),
  .chan_trigger_in(chan_trigger_in), .chan_fault_in(chan_fault_in),
  .channel_hold_disable_switch(channel_hold_disable_switch),
  .chan_step_out(chan_step_out), .chan_ready_out(chan_ready_out),
  .sys_ready_out(sys_ready_out), .sys_fault_ok_out(sys_fault_ok_out), .irq_out(irq_out));
`default_nettype wire

// *** tb/plc_model.sv ***
// stand-in for the customer plc driving the isolated trigger lines
`timescale 1ns/1ns
`default_nettype none
module plc_model #(
  parameter int NCH = 4,
  parameter int LAG = 1
) (
  input  wire logic           clk,
  input  wire logic           sys_req,
  input  wire logic [NCH-1:0] ch_req,
  output logic                system_trigger_input,
  output logic [NCH-1:0]      chan_trigger_in
);
  logic [LAG:0][NCH:0] pipe_ff;
  // requests reach the lines late, like a slow plc scan; levels are held, not pulsed
  always_ff @(posedge clk) begin
    pipe_ff[0] <= {sys_req, ch_req};
    for (int i = 1; i <= LAG; i++) pipe_ff[i] <= pipe_ff[i-1];
  end
  assign {system_trigger_input, chan_trigger_in} = pipe_ff[LAG];
endmodule : plc_model
`default_nettype wire

// *** tb/dispenser_trigger_ready_io_tb_top.sv ***
// register-driven tests of the trigger, ready and fault block
`timescale 1ns/1ns
`default_nettype none
`include "dispenser_cfg.svh"
module dispenser_trigger_ready_io_tb_top;
  logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, sys_req = 0, irq_out;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:0]  ch_req = 4'h0, fault = 4'h0, hold = 4'h0, ready, step, ch_trig;
  logic        sys_trig, sys_ready, fault_ok;
  logic [3:0]  sel = 4'h0;
  int          fails = 0, checked = 0, cyc = 0, nsteps = 0;
  always #5 clk = ~clk;
  plc_model #(.NCH(4), .LAG(1)) plc_model_i (.clk(clk), .sys_req(sys_req),
    .ch_req(ch_req), .system_trigger_input(sys_trig), .chan_trigger_in(ch_trig));
  dispenser_trigger_ready_io #(.NCH(4)) dispenser_trigger_ready_io_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .system_trigger_input(sys_trig), .chan_trigger_in(ch_trig),
    .chan_fault_in(fault), .channel_hold_disable_switch(hold),
    .chan_select_btn(sel), .chan_step_out(step), .chan_ready_out(ready),
    .sys_ready_out(sys_ready), .sys_fault_ok_out(fault_ok), .irq_out(irq_out));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // a hang is cut short well past the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // set trigger levels, then let sync, edge detect and the ready register settle
  task automatic trig(input logic s, input logic [3:0] c);
    @(posedge clk);
    sys_req <= s;
    ch_req <= c;
    tick(8);
  endtask : trig
  task automatic outs(input logic [3:0] r, input logic so, input logic fo);
    chk({26'h0, fault_ok, sys_ready, ready}, {26'h0, fo, so, r});
  endtask : outs
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(`OFS_ENABLE, 32'hf);
    rd(`OFS_MODE, 32'h0);
    rd(`OFS_REF, 32'hf);
    rd(`OFS_VOLUME, 32'h0);
    rd(8'h20, 32'h0);
    wr(`OFS_MODE, 32'h15);
    wr(`OFS_VOLUME, 32'h1);
    wr(`OFS_RATE, 32'hffff);
    trig(1'b0, 4'b0001);
    outs(4'hf, 1'b1, 1'b1);
    trig(1'b0, 4'b0000);
    wr(`OFS_REF, 32'hf);
    rd(`OFS_REF, 32'h0);
    // ch1 faulted, ch2 disabled, ch3 in prime: only ch0 may start
    wr(`OFS_ENABLE, 32'hb);
    fault <= 4'b0010;
    trig(1'b1, 4'b0000);
    outs(4'b1110, 1'b0, 1'b0);
    wr(`OFS_MODE, 32'h14);
    wr(`OFS_MODE, 32'h15);
    tick(8);
    outs(4'hf, 1'b1, 1'b0);
    trig(1'b0, 4'b0000);
    fault <= 4'b0000;
    wr(`OFS_MODE, 32'h16);
    trig(1'b1, 4'b0000);
    outs(4'b1100, 1'b0, 1'b1);
    trig(1'b0, 4'b0000);
    outs(4'b1101, 1'b0, 1'b1);
    wr(`OFS_MODE, 32'h55);
    fault <= 4'b0001;
    trig(1'b0, 4'b0010);
    outs(4'b1101, 1'b0, 1'b0);
    trig(1'b0, 4'b1011);
    outs(4'b0101, 1'b0, 1'b0);
    // 65535 rpm gives one step about every 458 cycles on each busy channel
    repeat (460) begin
      tick(1);
      nsteps += int'(step[1]);
    end
    chk(32'(nsteps), 32'h1);
    wr(`OFS_MODE, 32'h0);
    trig(1'b0, 4'b0000);
    fault <= 4'b0000;
    hold <= 4'b0001;
    tick(4);
    wr(`OFS_ENABLE, 32'hf);
    rd(`OFS_ENABLE, 32'he);
    hold <= 4'b0000;
    // a momentary select press toggles one channel's enable
    @(posedge clk);
    sel <= 4'b0100;
    tick(2);
    sel <= 4'b0000;
    tick(2);
    rd(`OFS_ENABLE, 32'ha);
    // trigger edge, meter stop and new fault all left status bits behind
    rd(`OFS_IRQ_STAT, 32'h7);
    chk({31'h0, irq_out}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h2);
    tick(2);
    chk({31'h0, irq_out}, 32'h1);
    wr(`OFS_IRQ_STAT, 32'h2);
    tick(2);
    chk({31'h0, irq_out}, 32'h0);
    wr(`OFS_IRQ_STAT, 32'h7);
    rd(`OFS_IRQ_STAT, 32'h0);
    conclude();
  end
endmodule : dispenser_trigger_ready_io_tb_top
`default_nettype wire
